// File: hdl/twl_regs.svh
`ifndef TWL_REGS_SVH
`define TWL_REGS_SVH

// timing: link clock period in ns and system clock period in ns
`define TWL_LINK_PERIOD_NS 400
`define TWL_CLK_PERIOD_NS  50
`define TWL_QTR_CYC (`TWL_LINK_PERIOD_NS / (4 * `TWL_CLK_PERIOD_NS))

// memory device addressing
`define TWL_DEV_BASE   7'h50
`define TWL_STRAP_ONE  3'h0
`define TWL_STRAP_TWO  3'h1
`define TWL_MEM_ADDR0  8'h00

// boot image layout
`define TWL_ID_BYTES   4'h8
`define TWL_LOAD_MARK  8'hc2
`define TWL_LOAD_MAX   15'h4000

// writable ram windows
`define TWL_CODE_LO    16'h0000
`define TWL_CODE_HI    16'h3fff
`define TWL_SCR_LO     16'he000
`define TWL_SCR_HI     16'he1ff
`endif

// File: hdl/twl_pkg.sv
package twl_pkg;
  typedef enum logic [1:0] {C_START, C_STOP, C_WR, C_RD} twl_cmd_t;
  typedef enum logic [1:0] {E_IDLE, E_START, E_BITS, E_STOP} twl_eng_t;
  typedef enum logic [3:0] {
    B_WAIT, B_S1, B_DW, B_A1, B_A0, B_S2, B_DR, B_RD, B_P, B_DONE
  } twl_boot_t;
  typedef enum logic [2:0] {P_ID, P_LH, P_LL, P_AH, P_AL, P_DAT} twl_parse_t;
endpackage : twl_pkg

// File: hdl/twl_boot_master.sv
`timescale 1ns/10ps
`include "twl_regs.svh"
module twl_boot_master #(
  parameter logic [3:0] QTR = 4'(`TWL_QTR_CYC)
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       scl_i,
  output      logic       scl_o,
  output      logic       scl_oe_o,
  input  wire logic       sda_i,
  output      logic       sda_o,
  output      logic       sda_oe_o,
  input  wire logic       cpu_go_i,
  input  wire logic [1:0] cpu_cmd_i,
  input  wire logic [7:0] cpu_wdata_i,
  input  wire logic       cpu_nack_i,
  output      logic [7:0] cpu_rdata_o,
  output      logic       cpu_ack_o,
  output      logic       cpu_done_o,
  output      logic       cpu_busy_o,
  output      logic       cpu_reset_o,
  output      logic       boot_done_o,
  output      logic       id_we_o,
  output      logic [3:0] id_idx_o,
  output      logic [7:0] id_data_o,
  output      logic       ram_we_o,
  output      logic [15:0] ram_addr_o,
  output      logic [7:0] ram_data_o
);
  // two-flop synchronisers on the open-drain lines
  logic scl_s1, scl_s, sda_s1, sda_s;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_s1 <= 1'b1;
      scl_s  <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s  <= 1'b1;
    end else begin
      scl_s1 <= scl_i;
      scl_s  <= scl_s1;
      sda_s1 <= sda_i;
      sda_s  <= sda_s1;
    end
  end
  // open drain: only the enables move, the driven level is always low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;

  // ---------------- byte engine ----------------
  twl_pkg::twl_eng_t st_r, st_nxt;
  twl_pkg::twl_cmd_t cmd_r, cmd_nxt, eng_cmd;
  logic [1:0] q_r, q_nxt;
  logic [3:0] tmr_r, tmr_nxt, bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt, eng_tx, crd_r, crd_nxt;
  logic       nk_r, nk_nxt, nak_r, nak_nxt, done_r, done_nxt;
  logic       scl_oe_r, scl_oe_nxt, sda_oe_r, sda_oe_nxt;
  logic       cdone_r, cdone_nxt, cack_r, cack_nxt, cbusy_r, cbusy_nxt;
  logic       eng_go, eng_nack, tick, boot_act, bgo;
  twl_pkg::twl_cmd_t bcmd;
  logic [7:0] btx;
  logic       bnack;

  assign boot_act = 1'b1;
  assign tick     = (tmr_r == 4'h0);
  // the loader owns the port until it finishes; cpu requests are dropped
  always_comb begin
    if (boot_done_o) begin
      eng_go   = cpu_go_i && (st_r == twl_pkg::E_IDLE);
      eng_cmd  = twl_pkg::twl_cmd_t'(cpu_cmd_i);
      eng_tx   = cpu_wdata_i;
      eng_nack = cpu_nack_i;
    end else begin
      eng_go   = bgo;
      eng_cmd  = bcmd;
      eng_tx   = btx;
      eng_nack = bnack;
    end
  end

  always_comb begin
    st_nxt = st_r;   cmd_nxt = cmd_r;  q_nxt = q_r;   bit_nxt = bit_r;
    sh_nxt = sh_r;   nk_nxt = nk_r;    nak_nxt = nak_r;
    scl_oe_nxt = scl_oe_r;  sda_oe_nxt = sda_oe_r;  done_nxt = 1'b0;
    tmr_nxt = tick ? QTR - 4'h1 : tmr_r - 4'h1;
    case (st_r)
      twl_pkg::E_IDLE: begin
        tmr_nxt = QTR - 4'h1;
        if (eng_go) begin
          cmd_nxt = eng_cmd;  sh_nxt = eng_tx;  nk_nxt = eng_nack;
          nak_nxt = 1'b0;     q_nxt = 2'h0;     bit_nxt = 4'h0;
          case (eng_cmd)
            twl_pkg::C_START: st_nxt = twl_pkg::E_START;
            twl_pkg::C_STOP:  st_nxt = twl_pkg::E_STOP;
            default:          st_nxt = twl_pkg::E_BITS;
          endcase
        end
      end
      twl_pkg::E_START: if (tick) begin
        case (q_r)
          2'h0: begin sda_oe_nxt = 1'b0; scl_oe_nxt = 1'b0; q_nxt = 2'h1; end
          2'h1: if (scl_s) begin sda_oe_nxt = 1'b1; q_nxt = 2'h2; end
          default: begin
            scl_oe_nxt = 1'b1; done_nxt = 1'b1; st_nxt = twl_pkg::E_IDLE;
          end
        endcase
      end
      twl_pkg::E_STOP: if (tick) begin
        case (q_r)
          2'h0: begin sda_oe_nxt = 1'b1; q_nxt = 2'h1; end
          2'h1: begin scl_oe_nxt = 1'b0; q_nxt = 2'h2; end
          default: if (scl_s) begin
            sda_oe_nxt = 1'b0; done_nxt = 1'b1; st_nxt = twl_pkg::E_IDLE;
          end
        endcase
      end
      twl_pkg::E_BITS: if (tick) begin
        case (q_r)
          2'h0: begin
            if (bit_r < 4'h8)
              sda_oe_nxt = (cmd_r == twl_pkg::C_WR) ? ~sh_r[7] : 1'b0;
            else
              sda_oe_nxt = (cmd_r == twl_pkg::C_WR) ? 1'b0 : ~nk_r;
            q_nxt = 2'h1;
          end
          2'h1: begin scl_oe_nxt = 1'b0; q_nxt = 2'h2; end
          // a slave holding scl low stretches the bit here
          2'h2: if (scl_s) begin
            if (bit_r < 4'h8)
              sh_nxt = {sh_r[6:0], sda_s};
            else if (cmd_r == twl_pkg::C_WR)
              nak_nxt = sda_s;
            q_nxt = 2'h3;
          end
          default: begin
            scl_oe_nxt = 1'b1;
            q_nxt = 2'h0;
            if (bit_r == 4'h8) begin
              done_nxt = 1'b1; st_nxt = twl_pkg::E_IDLE;
            end else
              bit_nxt = bit_r + 4'h1;
          end
        endcase
      end
      default: st_nxt = twl_pkg::E_IDLE;
    endcase
    cdone_nxt = done_nxt && boot_done_o;
    crd_nxt   = cdone_nxt ? sh_nxt : crd_r;
    cack_nxt  = cdone_nxt ? ~nak_nxt : cack_r;
    cbusy_nxt = ~boot_done_o || (st_nxt != twl_pkg::E_IDLE);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= twl_pkg::E_IDLE;  cmd_r <= twl_pkg::C_START;
      q_r <= 2'h0;  tmr_r <= 4'h0;  bit_r <= 4'h0;  sh_r <= 8'h00;
      nk_r <= 1'b0; nak_r <= 1'b0;  done_r <= 1'b0;
      scl_oe_r <= 1'b0;  sda_oe_r <= 1'b0;
      cdone_r <= 1'b0;   cack_r <= 1'b0;  cbusy_r <= 1'b1;  crd_r <= 8'h00;
    end else begin
      st_r <= st_nxt;  cmd_r <= cmd_nxt;  q_r <= q_nxt;  tmr_r <= tmr_nxt;
      bit_r <= bit_nxt;  sh_r <= sh_nxt;  nk_r <= nk_nxt;  nak_r <= nak_nxt;
      done_r <= done_nxt;
      scl_oe_r <= scl_oe_nxt;  sda_oe_r <= sda_oe_nxt;
      cdone_r <= cdone_nxt;  cack_r <= cack_nxt;  cbusy_r <= cbusy_nxt;
      crd_r <= crd_nxt;
    end
  end
  assign scl_oe_o    = scl_oe_r;
  assign sda_oe_o    = sda_oe_r;
  assign cpu_done_o  = cdone_r;
  assign cpu_ack_o   = cack_r;
  assign cpu_busy_o  = cbusy_r;
  assign cpu_rdata_o = crd_r;

  // ---------------- boot loader ----------------
  twl_pkg::twl_boot_t  bst_r, bst_nxt;
  twl_pkg::twl_parse_t pst_r, pst_nxt;
  logic        bw_r, bw_nxt, two_r, two_nxt, rt_r, rt_nxt, fin_r, fin_nxt;
  logic        ld_r, ld_nxt, last;
  logic [3:0]  idx_r, idx_nxt;
  logic [13:0] len_r, len_nxt;
  logic [15:0] adr_r, adr_nxt;
  logic [14:0] tot_r, tot_nxt;
  logic        idwe_nxt, rwe_nxt, crst_nxt, bdone_nxt;
  logic        idwe_r, rwe_r, crst_r, bdone_r, in_win;
  logic [3:0]  idix_r, idix_nxt;
  logic [7:0]  iddat_r, rdat_r, iddat_nxt, rdat_nxt;
  logic [15:0] radr_r, radr_nxt;
  logic [6:0]  dev;

  // the second probe address doubles as the wide-address flag
  assign dev = `TWL_DEV_BASE | {4'h0, two_r ? `TWL_STRAP_TWO
                                              : `TWL_STRAP_ONE};
  assign in_win = (adr_r <= `TWL_CODE_HI) ||
                  (adr_r >= `TWL_SCR_LO && adr_r <= `TWL_SCR_HI);
  // the final byte must be known before it is read so it can be nacked
  always_comb begin
    case (pst_r)
      twl_pkg::P_ID:  last = (idx_r == `TWL_ID_BYTES - 4'h1) && !ld_r;
      twl_pkg::P_AL:  last = fin_r;
      twl_pkg::P_DAT: last = (tot_r == `TWL_LOAD_MAX - 15'h1);
      default:        last = 1'b0;
    endcase
  end

  always_comb begin
    bst_nxt = bst_r;  pst_nxt = pst_r;  bw_nxt = bw_r;  two_nxt = two_r;
    rt_nxt = rt_r;    fin_nxt = fin_r;  ld_nxt = ld_r;  idx_nxt = idx_r;
    len_nxt = len_r;  adr_nxt = adr_r;  tot_nxt = tot_r;
    idwe_nxt = 1'b0;  rwe_nxt = 1'b0;   idix_nxt = idix_r;
    iddat_nxt = iddat_r;  rdat_nxt = rdat_r;  radr_nxt = radr_r;
    bgo = 1'b0;  bcmd = twl_pkg::C_START;  btx = 8'h00;  bnack = 1'b0;
    if (bst_r != twl_pkg::B_WAIT && bst_r != twl_pkg::B_DONE && !bw_r) begin
      bgo = 1'b1;
      bw_nxt = 1'b1;
    end
    if (done_r)
      bw_nxt = 1'b0;
    case (bst_r)
      // leaves this state once per power-on reset only
      twl_pkg::B_WAIT: bst_nxt = twl_pkg::B_S1;
      twl_pkg::B_S1: if (done_r) bst_nxt = twl_pkg::B_DW;
      twl_pkg::B_DW: begin
        bcmd = twl_pkg::C_WR;
        btx  = {dev, 1'b0};
        if (done_r) begin
          if (!nak_r)
            bst_nxt = two_r ? twl_pkg::B_A1 : twl_pkg::B_A0;
          else begin
            rt_nxt  = ~two_r;
            two_nxt = 1'b1;
            bst_nxt = twl_pkg::B_P;
          end
        end
      end
      twl_pkg::B_A1: begin
        bcmd = twl_pkg::C_WR;
        btx  = `TWL_MEM_ADDR0;
        if (done_r) bst_nxt = twl_pkg::B_A0;
      end
      twl_pkg::B_A0: begin
        bcmd = twl_pkg::C_WR;
        btx  = `TWL_MEM_ADDR0;
        if (done_r) bst_nxt = twl_pkg::B_S2;
      end
      twl_pkg::B_S2: if (done_r) bst_nxt = twl_pkg::B_DR;
      twl_pkg::B_DR: begin
        bcmd = twl_pkg::C_WR;
        btx  = {dev, 1'b1};
        if (done_r) bst_nxt = nak_r ? twl_pkg::B_P : twl_pkg::B_RD;
      end
      twl_pkg::B_RD: begin
        bcmd  = twl_pkg::C_RD;
        bnack = last;
        if (done_r) begin
          if (last) bst_nxt = twl_pkg::B_P;
          case (pst_r)
            twl_pkg::P_ID: begin
              idwe_nxt = 1'b1;  idix_nxt = idx_r;  iddat_nxt = sh_r;
              if (idx_r == 4'h0) ld_nxt = (sh_r == `TWL_LOAD_MARK);
              idx_nxt = idx_r + 4'h1;
              if (idx_r == `TWL_ID_BYTES - 4'h1) pst_nxt = twl_pkg::P_LH;
            end
            twl_pkg::P_LH: begin
              fin_nxt = sh_r[7];  len_nxt[13:8] = sh_r[5:0];
              pst_nxt = twl_pkg::P_LL;
            end
            twl_pkg::P_LL: begin
              len_nxt[7:0] = sh_r;  pst_nxt = twl_pkg::P_AH;
            end
            twl_pkg::P_AH: begin
              adr_nxt[15:8] = sh_r; pst_nxt = twl_pkg::P_AL;
            end
            twl_pkg::P_AL: begin
              adr_nxt[7:0] = sh_r;
              pst_nxt = (len_r == 14'h0000) ? twl_pkg::P_LH : twl_pkg::P_DAT;
            end
            default: begin
              // out-of-window bytes are consumed but never written
              rwe_nxt  = in_win;
              radr_nxt = adr_r;
              rdat_nxt = sh_r;
              adr_nxt  = adr_r + 16'h0001;
              len_nxt  = len_r - 14'h0001;
              tot_nxt  = tot_r + 15'h0001;
              if (len_r == 14'h0001) pst_nxt = twl_pkg::P_LH;
            end
          endcase
        end
      end
      twl_pkg::B_P: begin
        bcmd = twl_pkg::C_STOP;
        if (done_r) begin
          rt_nxt  = 1'b0;
          bst_nxt = rt_r ? twl_pkg::B_S1 : twl_pkg::B_DONE;
        end
      end
      twl_pkg::B_DONE: bst_nxt = twl_pkg::B_DONE;
      default:         bst_nxt = twl_pkg::B_DONE;
    endcase
    crst_nxt  = (bst_nxt != twl_pkg::B_DONE);
    bdone_nxt = (bst_nxt == twl_pkg::B_DONE);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bst_r <= twl_pkg::B_WAIT;  pst_r <= twl_pkg::P_ID;
      bw_r <= 1'b0;  two_r <= 1'b0;  rt_r <= 1'b0;  fin_r <= 1'b0;
      ld_r <= 1'b0;  idx_r <= 4'h0;  len_r <= 14'h0000;
      adr_r <= 16'h0000;  tot_r <= 15'h0000;
      idwe_r <= 1'b0;  rwe_r <= 1'b0;  crst_r <= 1'b1;  bdone_r <= 1'b0;
      idix_r <= 4'h0;  iddat_r <= 8'h00;  rdat_r <= 8'h00;
      radr_r <= 16'h0000;
    end else begin
      bst_r <= bst_nxt;  pst_r <= pst_nxt;  bw_r <= bw_nxt;
      two_r <= two_nxt;  rt_r <= rt_nxt;  fin_r <= fin_nxt;  ld_r <= ld_nxt;
      idx_r <= idx_nxt;  len_r <= len_nxt;  adr_r <= adr_nxt;
      tot_r <= tot_nxt;  idwe_r <= idwe_nxt;  rwe_r <= rwe_nxt;
      crst_r <= crst_nxt;  bdone_r <= bdone_nxt;  idix_r <= idix_nxt;
      iddat_r <= iddat_nxt;  rdat_r <= rdat_nxt;  radr_r <= radr_nxt;
    end
  end
  assign cpu_reset_o = crst_r;
  assign boot_done_o = bdone_r;
  assign id_we_o     = idwe_r;
  assign id_idx_o    = idix_r;
  assign id_data_o   = iddat_r;
  assign ram_we_o    = rwe_r;
  assign ram_addr_o  = radr_r;
  assign ram_data_o  = rdat_r;

  // ---------------- checks ----------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_cpu_held: assert property (
    (bst_r != twl_pkg::B_DONE) |-> cpu_reset_o)
    else $error("cpu left reset during boot load");
  a_ram_window: assert property (
    ram_we_o |-> (ram_addr_o <= `TWL_CODE_HI) ||
                 (ram_addr_o >= `TWL_SCR_LO && ram_addr_o <= `TWL_SCR_HI))
    else $error("boot write outside ram windows");
  a_boot_once: assert property (
    boot_done_o |=> boot_done_o && !cpu_reset_o)
    else $error("boot load restarted without power-on reset");
  a_cpu_locked: assert property (
    !boot_done_o |-> !cpu_done_o && cpu_busy_o)
    else $error("cpu reached the port during boot");
  a_load_limit: assert property (
    tot_r <= `TWL_LOAD_MAX)
    else $error("boot load exceeded size limit");
  a_wide_addr: assert property (
    (bst_r == twl_pkg::B_A1) |-> two_r)
    else $error("second address byte sent to narrow memory");
  a_idle_quiet: assert property (
    (st_r == twl_pkg::E_IDLE) && $past(st_r == twl_pkg::E_IDLE)
      |-> $stable(scl_oe_o) && $stable(sda_oe_o))
    else $error("port driven while engine idle");
  a_cpu_answer: assert property (
    boot_done_o && cpu_go_i && st_r == twl_pkg::E_IDLE &&
    cpu_cmd_i == 2'h0 |-> ##[6:40] cpu_done_o)
    else $error("cpu start not answered in time");
  a_probe_first: assert property (
    $rose(bst_r == twl_pkg::B_DW) |-> $past(bst_r) == twl_pkg::B_S1)
    else $error("device address sent without start");

  c_boot_end:  cover property ($rose(boot_done_o));
  c_ram_write: cover property (ram_we_o);
  c_retry:     cover property (rt_r && bst_r == twl_pkg::B_S1);
  c_cpu_xfer:  cover property (cpu_done_o && cpu_ack_o);
endmodule : twl_boot_master

// File: tb/twl_eeprom_model.sv
`timescale 1ns/10ps
module twl_eeprom_model (
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic [2:0] strap_i,
  input  wire logic       stretch_i,
  output      logic       scl_oe_o,
  output      logic       sda_oe_o
);
  logic [7:0] mem [0:63];
  logic [7:0] sh_r;
  logic [5:0] ptr_r;
  logic       act_r;
  logic       first_r;
  logic       sel_r;
  logic       rd_r;
  logic       nack_r;
  int         bc_r;
  int         nwr_r;
  initial begin
    act_r = 1'b0;
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
    nwr_r = 0;
  end
  // start or repeated start: a fresh device byte follows
  always @(negedge sda_i) if (scl_i) begin
    act_r = 1'b1;
    first_r = 1'b1;
    rd_r = 1'b0;
    bc_r = 0;
  end
  always @(posedge sda_i) if (scl_i) begin
    act_r = 1'b0;
    sda_oe_o = 1'b0;
  end
  always @(posedge scl_i) if (act_r) begin
    if (bc_r < 8) sh_r = {sh_r[6:0], sda_i};
    else nack_r = sda_i;
    bc_r++;
  end
  // changes only just after scl falls, so no false start or stop
  always @(negedge scl_i) if (act_r) begin
    sda_oe_o = 1'b0;
    // step past a byte only once the master has clocked it out of a read;
    // the device-address byte that opens the read must not move the pointer
    if (bc_r == 8 && rd_r) ptr_r++;
    if (bc_r == 8 && !rd_r) begin
      if (first_r) begin
        sel_r = (sh_r[7:1] == {4'ha, strap_i});
        rd_r = sh_r[0];
        first_r = 1'b0;
        if (!rd_r) ptr_r = 6'h00;
      end else if (sel_r) nwr_r++;
      sda_oe_o = sel_r;
    end
    if (bc_r == 9) begin
      bc_r = 0;
      // a nacked read ends the burst so the master can stop
      if (rd_r && nack_r) sel_r = 1'b0;
    end
    if (rd_r && sel_r && bc_r < 8) sda_oe_o = ~mem[ptr_r][7 - bc_r];
  end
  always @(negedge scl_i) if (stretch_i && act_r) begin
    scl_oe_o = 1'b1;
    #700 scl_oe_o = 1'b0;
  end
endmodule : twl_eeprom_model

// File: tb/twowire_boot_loader_master_test.sv
`timescale 1ns/10ps
module twowire_boot_loader_master_test;
  localparam logic [239:0] IMG_A =
    {128'hc201_0203_0405_0607_0003_0010_aabb_cc00,
     112'h0250_0011_2200_01e1_ff33_8000_0000};
  // image bytes are taken from the top, so the short image is left aligned
  localparam logic [239:0] IMG_B = {64'h5a11_2233_4455_6677, 176'h0};
  logic        clk_i;
  logic        rst_n_i;
  logic        go;
  logic        nack;
  logic        stretch;
  logic [1:0]  cmd;
  logic [7:0]  wdata;
  logic [2:0]  strap;
  logic        scl_oe, sda_oe, m_scl_oe, m_sda_oe;
  logic        busy, done, ack, cpu_rst, boot_done, id_we, ram_we;
  logic [7:0]  rdata, id_data, ram_data;
  logic [3:0]  id_idx;
  logic [15:0] ram_addr;
  wire         scl = ~scl_oe & ~m_scl_oe;
  wire         sda = ~sda_oe & ~m_sda_oe;
  int          errors, check_count, done_cnt, rst_bad;
  logic [11:0] id_q[$];
  logic [23:0] ram_q[$];
  initial clk_i = 1'b0;
  always #25 clk_i = ~clk_i;
  twl_boot_master i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl),
    .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
    .cpu_go_i(go), .cpu_cmd_i(cmd), .cpu_wdata_i(wdata), .cpu_nack_i(nack),
    .cpu_rdata_o(rdata), .cpu_ack_o(ack), .cpu_done_o(done),
    .cpu_busy_o(busy), .cpu_reset_o(cpu_rst), .boot_done_o(boot_done),
    .id_we_o(id_we), .id_idx_o(id_idx), .id_data_o(id_data),
    .ram_we_o(ram_we), .ram_addr_o(ram_addr), .ram_data_o(ram_data));
  twl_eeprom_model i_mem (.scl_i(scl), .sda_i(sda), .strap_i(strap),
    .stretch_i(stretch), .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe));
  always @(posedge clk_i) begin
    if (id_we === 1'b1) id_q.push_back({id_idx, id_data});
    if (ram_we === 1'b1) ram_q.push_back({ram_addr, ram_data});
    if ((id_we | ram_we) === 1'b1 && cpu_rst !== 1'b1) rst_bad++;
    if (done === 1'b1) done_cnt++;
  end
  task automatic check(input string nm, input logic [23:0] exp,
                       input logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  // power-on, with a cpu request that must be ignored while loading
  task automatic boot(input logic [2:0] s, input logic st,
                      input logic [239:0] img, input int nid);
    int n;
    @(negedge clk_i);
    rst_n_i = 1'b0;
    strap = s;
    stretch = st;
    for (n = 0; n < 30; n++) i_mem.mem[n] = img[239 - 8 * n -: 8];
    repeat (20) @(negedge clk_i);
    id_q.delete();
    ram_q.delete();
    done_cnt = 0;
    rst_bad = 0;
    i_mem.nwr_r = 0;
    rst_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    check("cpu_rst_boot", 1, cpu_rst);
    go = 1'b1;
    @(negedge clk_i);
    go = 1'b0;
    n = 0;
    while (boot_done !== 1'b1) begin
      n++;
      if (n > 30000) begin
        errors++;
        conclude();
      end
      @(negedge clk_i);
    end
    check("cpu_rst_end", 0, cpu_rst);
    check("go_refused", 0, done_cnt);
    check("rst_held", 0, rst_bad);
    check("id_count", nid, id_q.size());
    for (n = 0; n < nid; n++)
      check("id_byte", {n[3:0], img[239 - 8 * n -: 8]}, id_q[n]);
  endtask : boot
  task automatic op(input logic [1:0] c, input logic [7:0] d,
                    input logic k, input logic [8:0] exp);
    int n;
    @(negedge clk_i);
    go = 1'b1;
    cmd = c;
    wdata = d;
    nack = k;
    @(negedge clk_i);
    go = 1'b0;
    n = 0;
    while (done !== 1'b1) begin
      @(posedge clk_i);
      #1;
      n++;
      if (n > 4000) begin
        errors++;
        conclude();
      end
    end
    if (c[1]) check("cpu_op", exp, {ack, rdata});
  endtask : op
  task automatic t_absent();
    boot(3'h7, 1'b0, IMG_A, 0);
    check("no_load", 0, ram_q.size());
  endtask : t_absent
  task automatic t_small();
    logic [23:0] exp [4];
    exp = '{24'h00_10aa, 24'h00_11bb, 24'h00_12cc, 24'he1_ff33};
    boot(3'h0, 1'b0, IMG_A, 8);
    check("addr_bytes", 1, i_mem.nwr_r);
    // the 0x5000 record must not reach ram
    check("ram_count", 4, ram_q.size());
    for (int i = 0; i < 4; i++) check("ram_wr", exp[i], ram_q[i]);
  endtask : t_small
  task automatic t_large();
    boot(3'h1, 1'b1, IMG_B, 8);
    check("addr_bytes", 2, i_mem.nwr_r);
    check("no_load", 0, ram_q.size());
  endtask : t_large
  // slow partner still attached from t_large
  task automatic t_cpu();
    op(2'd0, 8'h00, 1'b0, 9'h000);
    op(2'd2, 8'ha2, 1'b0, 9'h1a2);
    op(2'd2, 8'h00, 1'b0, 9'h100);
    op(2'd2, 8'h00, 1'b0, 9'h100);
    op(2'd0, 8'h00, 1'b0, 9'h000);
    op(2'd2, 8'ha3, 1'b0, 9'h1a3);
    op(2'd3, 8'h00, 1'b0, 9'h15a);
    op(2'd3, 8'h00, 1'b1, 9'h111);
    op(2'd1, 8'h00, 1'b0, 9'h000);
    op(2'd0, 8'h00, 1'b0, 9'h000);
    op(2'd2, 8'ha0, 1'b0, 9'h0a0);
    op(2'd1, 8'h00, 1'b0, 9'h000);
    check("no_reboot", 8, id_q.size());
    check("cpu_busy", 0, busy);
  endtask : t_cpu
  initial begin
    rst_n_i = 1'b0;
    go = 1'b0;
    nack = 1'b0;
    stretch = 1'b0;
    cmd = 2'd0;
    wdata = 8'h00;
    strap = 3'h0;
    errors = 0;
    check_count = 0;
    t_absent();
    t_small();
    t_large();
    t_cpu();
    conclude();
  end
endmodule : twowire_boot_loader_master_test
